// >>> core/wad_core.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps

module wad_fifo import wad_pkg::*; #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} wad_fifo_st_t;
	wad_fifo_st_t s;
	wad_fifo_st_t n;
	logic full;
	logic empty;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("fifo depth must be a power of two");
	end

	// extra pointer bit tells full from empty
	assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
	assign empty = s.wp == s.rp;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = s.mem[s.rp[AW-1:0]];

	always_comb begin
		n = s;
		if (in_valid && !full) begin
			n.mem[s.wp[AW-1:0]] = in_data;
			n.wp = s.wp + 1'h1;
		end
		if (out_ready && !empty) begin
			n.rp = s.rp + 1'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule // wad_fifo

module wad_core import wad_pkg::*; #(
	parameter int TAPS = 32,
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter samples
	input wire logic samp_valid,
	input wire logic [SAMP_W-1:0] samp_a,
	input wire logic [SAMP_W-1:0] samp_b,
	// timing input and sync bus
	input wire logic tim_in,
	input wire logic sb_gate,
	input wire logic sb_reset,
	input wire logic sb_refclk_in,
	output logic sb_refclk_out,
	// bank write lanes
	output wad_bwr_t bwr0,
	output wad_bwr_t bwr1,
	// bank read port
	output wad_rdq_t rd,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	// host stream
	output logic host_valid,
	input wire logic host_ready,
	output logic [31:0] host_data,
	// downconverter outputs
	output wad_iq_t ddc0,
	output wad_iq_t ddc1
);
	localparam int KW = $clog2(TAPS);

	typedef struct packed {
		logic [C_W-1:0] ctrl;
		logic [1:0][31:0] tune;
		logic [1:0][31:0] phs;
		logic [1:0][TAPS-1:0][COEF_W-1:0] coef;
		logic [3:0][31:0] desc;
		logic [31:0] prdata;
		logic perr;
		logic [SAMP_W-1:0] tg;
		logic [1:0] rr;
		logic [3:0][BANK_AW-1:0] ptr;
		logic done;
		wad_bwr_t bwr0;
		wad_bwr_t bwr1;
		logic [31:0] ts;
		logic [31:0] pps_ts;
		logic tim_d;
		logic refclk;
		logic [1:0][31:0] ph;
		logic [1:0][KW-1:0] k;
		logic [1:0][ACC_W-1:0] ai;
		logic [1:0][ACC_W-1:0] aq;
		logic [1:0] iv;
		logic [1:0][IQ_W-1:0] io;
		logic [1:0][IQ_W-1:0] qo;
		wad_dma_st_t dst;
		logic [1:0] di;
		logic [31:0] cur;
		logic [BANK_AW-1:0] addr;
		logic [LEN_W-1:0] cnt;
		logic [LEN_W-1:0] xcnt;
		logic [31:0] mark;
		logic tail;
		wad_rdq_t rd;
	} wad_core_st_t;

	wad_core_st_t s;
	wad_core_st_t n;
	logic two;
	logic gate_now;
	logic sync_ev;
	logic pps_ev;
	logic go;
	logic [5:0] dn;
	logic [SAMP_W-1:0] sa;
	logic [SAMP_W-1:0] sb;
	logic f_valid;
	logic f_ready;
	logic [31:0] f_data;

	if (TAPS < 32 || (1 << KW) != TAPS) begin : g_chk
		$error("taps must be a power of two covering the largest decimation");
	end

	function automatic logic [5:0] dec_n(input logic two_ch, input logic [1:0] code);
		logic [1:0] c;
		c = (code > DEC_MAX) ? DEC_MAX : code;
		return (two_ch ? DEC_TWO : DEC_ONE) << c;
	endfunction

	// quadrant rotation; cheap stand-in for a sine table
	function automatic logic signed [SAMP_W:0] mixv(input logic signed [SAMP_W:0] x,
		input logic [1:0] q, input logic im);
		logic signed [SAMP_W:0] r;
		r = (q[0] == im) ? x : '0;
		return (q[1] ^ im) ? -r : r;
	endfunction

	function automatic logic reg_ok(input logic [APB_AW-1:0] a);
		case (a)
			A_CTRL, A_STAT, A_TUNE0, A_TUNE1, A_PHS0, A_PHS1, A_COEF, A_TS, A_PPS, A_XCNT: begin
				reg_ok = 1'h1;
			end
			default: begin
				reg_ok = (a[APB_AW-1:4] == A_DESC[APB_AW-1:4]) && (a[1:0] == 2'h0);
			end
		endcase
	endfunction

	assign two = s.ctrl[C_TWO];
	assign dn = dec_n(two, s.ctrl[C_DEC+:2]);
	assign sa = s.ctrl[C_SRC] ? s.tg : samp_a;
	assign sb = s.ctrl[C_SRC] ? ~s.tg : samp_b;
	assign gate_now = (s.ctrl[C_TFN+:2] == TF_GATE && tim_in) || sb_gate;
	assign pps_ev = s.ctrl[C_TFN+:2] == TF_PPS && tim_in && !s.tim_d;
	assign sync_ev = (s.ctrl[C_TFN+:2] == TF_SYNC && tim_in && !s.tim_d) || sb_reset;
	assign go = psel && penable && pwrite && paddr == A_CTRL && pwdata[C_START];

	always_comb begin
		logic [1:0] q;
		logic [31:0] wsum;
		logic signed [SAMP_W:0] x;
		logic signed [ACC_W-1:0] pi;
		logic signed [ACC_W-1:0] pq;
		n = s;
		q = '0;
		wsum = '0;
		x = '0;
		pi = '0;
		pq = '0;
		// apb: read data registered in setup, so no wait states
		if (psel && !penable) begin
			n.perr = !reg_ok(paddr);
			n.prdata = '0;
			case (paddr)
				A_CTRL: n.prdata = 32'(s.ctrl);
				A_STAT: begin
					n.prdata[S_DONE] = s.done;
					n.prdata[S_BUSY] = s.dst != DS_IDLE;
					n.prdata[S_DMA+:3] = s.dst;
				end
				A_TUNE0: n.prdata = s.tune[0];
				A_TUNE1: n.prdata = s.tune[1];
				A_PHS0: n.prdata = s.phs[0];
				A_PHS1: n.prdata = s.phs[1];
				A_TS: n.prdata = s.ts;
				A_PPS: n.prdata = s.pps_ts;
				A_XCNT: n.prdata = 32'(s.xcnt);
				default: begin
					if (reg_ok(paddr) && paddr != A_COEF) begin
						n.prdata = s.desc[paddr[3:2]];
					end
				end
			endcase
		end
		if (psel && penable && pwrite && reg_ok(paddr)) begin
			case (paddr)
				A_CTRL: begin
					n.ctrl = pwdata[C_W-1:0];
					n.ctrl[C_START] = 1'h0;
					// a fresh run restarts the banks from the bottom and realigns both decimation windows,
					// so the two channels of a two-channel run emit in step
					if (pwdata[C_RUN] && !s.ctrl[C_RUN]) begin
						n.ptr = '0;
						n.done = 1'h0;
						n.rr = '0;
						n.k = '0;
						n.ai = '0;
						n.aq = '0;
					end
				end
				A_TUNE0: n.tune[0] = pwdata;
				A_TUNE1: n.tune[1] = pwdata;
				A_PHS0: n.phs[0] = pwdata;
				A_PHS1: n.phs[1] = pwdata;
				A_COEF: n.coef[pwdata[CF_CH]][pwdata[CF_IDX+:KW]] = pwdata[COEF_W-1:0];
				A_STAT, A_TS, A_PPS, A_XCNT: n.done = s.done;
				default: n.desc[paddr[3:2]] = pwdata;
			endcase
		end
		// timing
		n.tim_d = tim_in;
		n.refclk = sb_refclk_in;
		if (sync_ev) begin
			n.ts = '0;
			n.ph = '0;
		end else if (samp_valid) begin
			n.ts = s.ts + 32'h0000_0001;
		end
		if (pps_ev) begin
			n.pps_ts = s.ts;
		end
		// bank steering
		n.bwr0.valid = 1'h0;
		n.bwr1.valid = 1'h0;
		if (samp_valid && s.ctrl[C_RUN]) begin
			n.tg = s.tg + 1'h1;
			if (!s.done && !two) begin
				n.bwr0 = '{valid: 1'h1, bank: s.rr, addr: s.ptr[s.rr], data: sa};
				n.ptr[s.rr] = s.ptr[s.rr] + 1'h1;
				n.rr = s.rr + 2'h1;
				n.done = s.ctrl[C_CAPT] && s.ptr[s.rr] == BANK_LAST;
			end else if (!s.done) begin
				n.bwr0 = '{valid: 1'h1, bank: {1'h0, s.rr[0]}, addr: s.ptr[{1'h0, s.rr[0]}], data: sa};
				n.bwr1 = '{valid: 1'h1, bank: {1'h1, s.rr[0]}, addr: s.ptr[{1'h1, s.rr[0]}], data: sb};
				n.ptr[{1'h0, s.rr[0]}] = s.ptr[{1'h0, s.rr[0]}] + 1'h1;
				n.ptr[{1'h1, s.rr[0]}] = s.ptr[{1'h1, s.rr[0]}] + 1'h1;
				n.rr = {1'h0, !s.rr[0]};
				n.done = s.ctrl[C_CAPT] && (s.ptr[{1'h0, s.rr[0]}] == BANK_LAST ||
					s.ptr[{1'h1, s.rr[0]}] == BANK_LAST);
			end
		end
		// downconverters; the second runs only in two-channel mode
		n.iv = '0;
		for (int c = 0; c < 2; c++) begin
			if (samp_valid && s.ctrl[C_RUN] && (c == 0 || two)) begin
				x = (c == 0) ? $signed({sa[SAMP_W-1], sa}) : $signed({sb[SAMP_W-1], sb});
				if (!sync_ev) begin
					n.ph[c] = s.ph[c] + s.tune[c];
				end
				wsum = s.ph[c] + s.phs[c];
				q = wsum[31:30];
				pi = ACC_W'(mixv(x, q, 1'h0) * $signed(s.coef[c][s.k[c]]));
				pq = ACC_W'(mixv(x, q, 1'h1) * $signed(s.coef[c][s.k[c]]));
				pi = $signed(s.ai[c]) + pi;
				pq = $signed(s.aq[c]) + pq;
				// >= also recovers when decimation shrinks mid-window
				if (6'(s.k[c]) >= dn - 6'h01) begin
					n.iv[c] = 1'h1;
					n.io[c] = pi[ACC_SH+IQ_W-1:ACC_SH];
					n.qo[c] = pq[ACC_SH+IQ_W-1:ACC_SH];
					n.k[c] = '0;
					n.ai[c] = '0;
					n.aq[c] = '0;
				end else begin
					n.k[c] = s.k[c] + 1'h1;
					n.ai[c] = pi;
					n.aq[c] = pq;
				end
			end
		end
		// linked-list dma
		n.rd.req = 1'h0;
		case (s.dst)
			DS_IDLE: begin
				if (go) begin
					n.di = pwdata[C_DESC+:2];
					n.dst = DS_LOAD;
				end
			end
			DS_LOAD: begin
				n.cur = s.desc[s.di];
				n.addr = '0;
				n.cnt = '0;
				n.tail = 1'h0;
				n.mark = s.ts;
				if (s.desc[s.di][D_GATE]) begin
					n.dst = DS_GWAIT;
				end else begin
					n.dst = s.ctrl[C_META] ? DS_HDR0 : DS_REQ;
				end
			end
			DS_GWAIT: begin
				if (gate_now) begin
					n.mark = s.ts;
					n.dst = DS_REQ;
				end
			end
			DS_HDR0: begin
				if (f_ready) begin
					n.dst = DS_HDR1;
				end
			end
			DS_HDR1: begin
				if (f_ready) begin
					n.dst = s.tail ? DS_NEXT : DS_REQ;
				end
			end
			DS_REQ: begin
				if (s.cur[D_GATE] ? (!gate_now || &s.cnt) : s.cnt == s.cur[D_LEN+:LEN_W]) begin
					n.xcnt = s.cnt;
					n.tail = s.cur[D_GATE];
					n.dst = (s.cur[D_GATE] && s.ctrl[C_META]) ? DS_HDR0 : DS_NEXT;
				end else if (f_ready) begin
					// only one read outstanding, so a free slot is always there for it
					n.rd = '{req: 1'h1, bank: s.cur[D_BANK+:2], addr: s.addr};
					n.dst = DS_WAIT;
				end
			end
			DS_WAIT: begin
				if (rd_valid) begin
					n.cnt = s.cnt + 1'h1;
					n.addr = s.addr + 1'h1;
					n.dst = DS_REQ;
				end
			end
			DS_NEXT: begin
				if (s.cur[D_LAST]) begin
					n.dst = DS_IDLE;
				end else begin
					n.di = s.cur[D_NEXT+:2];
					n.dst = DS_LOAD;
				end
			end
			default: n.dst = DS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s <= '0;
			s.coef <= {(2 * TAPS){COEF_DEF}};
		end else begin
			s <= n;
		end
	end

	assign f_valid = s.dst == DS_HDR0 || s.dst == DS_HDR1 || (s.dst == DS_WAIT && rd_valid);
	assign f_data = (s.dst == DS_HDR0) ? s.mark :
		(s.dst == DS_HDR1) ? {META_TAG, s.tail ? s.cnt : s.cur[D_LEN+:LEN_W]} : rd_data;

	wad_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.srst(srst),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_data),
		.out_valid(host_valid),
		.out_ready(host_ready),
		.out_data(host_data)
	);

	assign prdata = s.prdata;
	assign pready = psel && penable;
	assign pslverr = s.perr && psel && penable;
	assign sb_refclk_out = s.refclk;
	assign bwr0 = s.bwr0;
	assign bwr1 = s.bwr1;
	assign rd = s.rd;
	assign ddc0 = {s.iv[0], s.io[0], s.qo[0]};
	assign ddc1 = {s.iv[1], s.io[1], s.qo[1]};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	src_adc_a: assert property (
		bwr0.valid && !$past(s.ctrl[C_SRC]) |-> bwr0.data == $past(samp_a)
	) else $error("bank data does not follow the converter");
	one_rot_a: assert property (
		(bwr0.valid && !two) ##1 (bwr0.valid && !two) |-> bwr0.bank == 2'($past(bwr0.bank) + 2'h1)
	) else $error("one-channel bank rotation broken");
	two_split_a: assert property (
		bwr0.valid && $past(two) |-> !bwr0.bank[1] && bwr1.valid && bwr1.bank[1] && bwr1.bank[0] == bwr0.bank[0]
	) else $error("two-channel bank split broken");
	capt_hold_a: assert property (
		$past(s.done) && s.done |-> !bwr0.valid && !bwr1.valid
	) else $error("write after capture filled");
	rd_single_a: assert property (
		rd.req |=> !rd.req
	) else $error("second read issued while one outstanding");
	gate_stop_a: assert property (
		s.dst == DS_REQ && s.cur[D_GATE] && !gate_now |=> !rd.req && s.dst != DS_WAIT
	) else $error("read issued after gate closed");
	nco_step_a: assert property (
		$past(samp_valid && s.ctrl[C_RUN] && !sync_ev) |-> s.ph[0] == 32'($past(s.ph[0]) + $past(s.tune[0]))
	) else $error("oscillator phase did not advance by the tuning word");
	dec_len_a: assert property (
		ddc0.valid |-> 6'($past(s.k[0])) >= 6'($past(dn) - 6'h01)
	) else $error("output before decimation window complete");
	ddc_rate_a: assert property (
		ddc0.valid |=> !ddc0.valid [*3]
	) else $error("downconverter output faster than decimation allows");
	pps_mark_a: assert property (
		pps_ev |=> s.pps_ts == $past(s.ts)
	) else $error("pps timestamp not captured");
	sync_clr_a: assert property (
		sb_reset |=> s.ts == 32'h0000_0000
	) else $error("sync reset did not clear the sample clock count");
	meta_len_a: assert property (
		s.dst == DS_HDR1 && s.tail |-> f_data[LEN_W-1:0] == s.xcnt && f_data[LEN_W-1:0] == s.cnt
	) else $error("gate metadata length differs from samples moved");
endmodule // wad_core

// >>> common/wad_pkg.sv
package wad_pkg;
	// widths
	localparam int SAMP_W = 12;
	localparam int IQ_W = 16;
	localparam int COEF_W = 16;
	localparam int ACC_W = 34;
	localparam int ACC_SH = 18;
	localparam int BANK_AW = 28;
	localparam int LEN_W = 20;
	localparam int APB_AW = 8;
	localparam logic [BANK_AW-1:0] BANK_LAST = '1;
	localparam logic [COEF_W-1:0] COEF_DEF = 16'h0800;
	localparam logic [11:0] META_TAG = 12'h3a5;
	localparam logic [5:0] DEC_ONE = 6'h08;
	localparam logic [5:0] DEC_TWO = 6'h04;
	localparam logic [1:0] DEC_MAX = 2'h2;
	// register byte offsets
	localparam logic [APB_AW-1:0] A_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] A_STAT = 8'h04;
	localparam logic [APB_AW-1:0] A_TUNE0 = 8'h08;
	localparam logic [APB_AW-1:0] A_TUNE1 = 8'h0c;
	localparam logic [APB_AW-1:0] A_PHS0 = 8'h10;
	localparam logic [APB_AW-1:0] A_PHS1 = 8'h14;
	localparam logic [APB_AW-1:0] A_COEF = 8'h18;
	localparam logic [APB_AW-1:0] A_TS = 8'h1c;
	localparam logic [APB_AW-1:0] A_PPS = 8'h20;
	localparam logic [APB_AW-1:0] A_XCNT = 8'h24;
	localparam logic [APB_AW-1:0] A_DESC = 8'h30;
	// control fields
	localparam int C_SRC = 0;
	localparam int C_TWO = 1;
	localparam int C_CAPT = 2;
	localparam int C_DEC = 3;
	localparam int C_TFN = 5;
	localparam int C_META = 7;
	localparam int C_START = 8;
	localparam int C_RUN = 9;
	localparam int C_DESC = 10;
	localparam int C_W = 12;
	// coefficient write fields
	localparam int CF_IDX = 16;
	localparam int CF_CH = 31;
	// descriptor fields
	localparam int D_LEN = 0;
	localparam int D_BANK = 20;
	localparam int D_NEXT = 22;
	localparam int D_LAST = 24;
	localparam int D_GATE = 25;
	// status fields
	localparam int S_DONE = 0;
	localparam int S_BUSY = 1;
	localparam int S_DMA = 4;

	typedef enum logic [1:0] {
		TF_GATE = 2'b00,
		TF_PPS = 2'b01,
		TF_SYNC = 2'b10,
		TF_OFF = 2'b11
	} wad_tfn_t;

	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_LOAD = 3'b001,
		DS_GWAIT = 3'b010,
		DS_HDR0 = 3'b011,
		DS_HDR1 = 3'b100,
		DS_REQ = 3'b101,
		DS_WAIT = 3'b110,
		DS_NEXT = 3'b111
	} wad_dma_st_t;

	typedef struct packed {
		logic valid;
		logic [1:0] bank;
		logic [BANK_AW-1:0] addr;
		logic [SAMP_W-1:0] data;
	} wad_bwr_t;

	typedef struct packed {
		logic valid;
		logic [IQ_W-1:0] i;
		logic [IQ_W-1:0] q;
	} wad_iq_t;

	typedef struct packed {
		logic req;
		logic [1:0] bank;
		logic [BANK_AW-1:0] addr;
	} wad_rdq_t;
endpackage

// >>> tb/wad_adc_model.sv
`timescale 1ns/100ps

module wad_adc_model import wad_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// sample side
	input wire logic en,
	output logic samp_valid,
	output logic [SAMP_W-1:0] samp_a,
	output logic [SAMP_W-1:0] samp_b,
	// bank read side
	input wire wad_rdq_t rd,
	output logic rd_valid,
	output logic [31:0] rd_data
);
	logic [31:0] word;
	logic [2:0] cnt;
	logic busy;
	logic slow;

	always_ff @(posedge mclk) begin
		rd_valid <= 1'b0;
		rd_data <= ~rd_data;
		if (srst) begin
			samp_valid <= 1'b0;
			samp_a <= 12'h000;
			samp_b <= 12'h7ff;
			busy <= 1'b0;
			slow <= 1'b0;
			rd_data <= 32'h0000_0000;
		end else begin
			// full-rate stream; parked lines toggle so nothing stale looks valid
			samp_valid <= en;
			samp_a <= en ? samp_a + 12'h005 : ~samp_a;
			samp_b <= en ? samp_b - 12'h003 : ~samp_b;
			// bank content tells bank and address apart
			if (rd.req) begin
				word <= {2'b00, rd.bank, rd.addr};
				cnt <= slow ? 3'h4 : 3'h0;
				slow <= ~slow;
				busy <= 1'b1;
			end else if (busy && cnt == 3'h0) begin
				rd_valid <= 1'b1;
				rd_data <= word;
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 3'h1;
			end
		end
	end
endmodule // wad_adc_model

// >>> tb/wad_core_tb.sv
`timescale 1ns/100ps

module wad_core_tb import wad_pkg::*; ;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd_data, host_data, r;
	logic pready, pslverr, err, samp_valid, rd_valid, host_valid, sb_refclk_out;
	logic [SAMP_W-1:0] samp_a, samp_b;
	logic en = 1'b0;
	logic tim_in = 1'b0;
	logic sb_reset = 1'b0;
	logic sb_gate = 1'b0;
	logic sb_refclk_in = 1'b0;
	logic host_ready = 1'b0;
	wad_bwr_t bwr0, bwr1;
	wad_rdq_t rd;
	wad_iq_t ddc0, ddc1;
	int n_fail = 0;
	int num_checks = 0;
	int nreq = 0;
	int k, n;
	logic [31:0] q[$];

	always #12.5 mclk = ~mclk;
	always @(posedge mclk) sb_refclk_in <= ~sb_refclk_in;
	always @(posedge mclk) if (rd.req === 1'b1) nreq <= nreq + 1;

	wad_core #(.TAPS(32), .FIFO_DEPTH(8)) i_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .samp_valid, .samp_a, .samp_b, .tim_in, .sb_gate, .sb_reset,
		.sb_refclk_in, .sb_refclk_out, .bwr0, .bwr1, .rd, .rd_valid, .rd_data, .host_valid, .host_ready,
		.host_data, .ddc0, .ddc1);
	wad_adc_model i_adc (.mclk, .srst, .en, .samp_valid, .samp_a, .samp_b, .rd, .rd_valid, .rd_data);

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic to();
		n_fail++;
		finish_test();
	endtask

	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// request stands until pready is seen at a rising edge; data taken at that edge
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) to();
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [APB_AW-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask

	// walks the bank lanes; gen expects a ramp instead of the converter values
	task automatic path(input logic [31:0] c, input int two, input int gen);
		logic [SAMP_W-1:0] pa, pb;
		int i, j;
		wr(A_CTRL, c);
		en <= 1'b1;
		j = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk);
			#1;
			if (bwr0.valid === 1'b1) begin
				chk(bwr0.bank, 32'(two ? j % 2 : j % 4));
				chk(bwr0.addr, 32'(two ? j / 2 : j / 4));
				if (!gen) chk(bwr0.data, pa);
				if (gen && j > 0) chk(bwr0.data, 12'(pa + 12'h001));
				if (gen) pa = bwr0.data;
				if (two) chk({bwr1.valid, bwr1.bank, bwr1.data}, {1'b1, 2'(2 + j % 2), pb});
				j++;
			end
			if (!gen) pa = samp_a;
			pb = samp_b;
		end
		chk(32'(j > 30), 1);
		en <= 1'b0;
		wr(A_CTRL, 32'h0000_0000);
	endtask

	// pulse spacing of the decimated output; z expects a zeroed filter on ch0
	task automatic dec(input logic [31:0] c, input int nd, input int two, input int np, input int z);
		int i, p, t;
		logic nz;
		wr(A_CTRL, c);
		en <= 1'b1;
		p = 0;
		nz = 1'b0;
		for (i = 0; i < 400 && p < np; i++) begin
			@(posedge mclk);
			#1;
			if (ddc0.valid === 1'b1) begin
				p++;
				if (p > 2) chk(32'(i - t), nd);
				if (two) chk(ddc1.valid, 1);
				if (z && p > 2) chk({ddc0.i, ddc0.q}, 32'h0000_0000);
				nz = nz | (z ? |{ddc1.i, ddc1.q} : |{ddc0.i, ddc0.q});
				t = i;
			end
		end
		chk(32'(p), np);
		chk(nz, 1);
		en <= 1'b0;
		wr(A_CTRL, 32'h0000_0000);
	endtask

	task automatic drain(input int nw, input int g);
		int i;
		q.delete();
		@(posedge mclk);
		host_ready <= 1'b1;
		for (i = 0; i < 2000 && q.size() < nw; i++) begin
			#1;
			if (host_valid === 1'b1) q.push_back(host_data);
			@(posedge mclk);
			if (g && q.size() > 0 && q[$][31:20] == 12'h3a5) break;
		end
		host_ready <= 1'b0;
		if (i == 2000) to();
	endtask

	initial begin
		#2_500_000;
		to();
	end

	initial begin
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		rdc(A_CTRL, 32'h0000_0000);
		rdc(A_STAT, 32'h0000_0000);
		for (k = 0; k < 4; k++) wr(A_TUNE0 + 8'(4 * k), 32'ha5c3_0f00 + k);
		for (k = 0; k < 4; k++) rdc(A_TUNE0 + 8'(4 * k), 32'ha5c3_0f00 + k);
		wr(A_STAT, 32'hffff_ffff);
		rdc(A_STAT, 32'h0000_0000);
		rdc(A_COEF, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk(err, 1);
		for (k = 0; k < 6; k++) begin
			@(posedge mclk);
			#1;
			chk(sb_refclk_out, !sb_refclk_in);
		end
		path(32'h0000_0200, 0, 0);
		path(32'h0000_0202, 1, 0);
		path(32'h0000_0201, 0, 1);
		for (k = 0; k < 3; k++) dec(32'h0000_0200 | (k << 3), 8 << k, 0, 4, 0);
		for (k = 0; k < 3; k++) dec(32'h0000_0202 | (k << 3), 4 << k, 1, 4, 0);
		for (k = 0; k < 32; k++) wr(A_COEF, k << CF_IDX);
		dec(32'h0000_0202, 4, 1, 8, 1);
		// fixed length 10 from bank 1, host stalls until the fifo refuses
		wr(A_DESC, 32'h0110_000a);
		n = nreq;
		wr(A_CTRL, 32'h0000_0180);
		repeat (80) @(posedge mclk);
		chk(32'(nreq - n), 6);
		drain(12, 0);
		chk(q[1], {12'h3a5, 20'd10});
		for (k = 0; k < 10; k++) chk(q[k + 2], {4'h1, 28'(k)});
		#1;
		chk(host_valid, 0);
		apb(1'b0, A_STAT, 32'h0000_0000);
		chk(r & 32'h0000_0072, 0);
		rdc(A_XCNT, 32'h0000_000a);
		// gate-sized transfer from bank 2, trailer after the data
		wr(A_DESC, 32'h0320_0000);
		wr(A_CTRL, 32'h0000_0380);
		en <= 1'b1;
		repeat (4) @(posedge mclk);
		tim_in <= 1'b1;
		repeat (20) @(posedge mclk);
		tim_in <= 1'b0;
		drain(200, 1);
		n = q.size();
		chk(32'(n > 2), 1);
		chk(q[n - 1], {12'h3a5, 20'(n - 2)});
		for (k = 0; k < n - 2; k++) chk(q[k], {4'h2, 28'(k)});
		rdc(A_XCNT, 32'(n - 2));
		// same descriptor, timing input off, gate from the sync bus
		wr(A_CTRL, 32'h0000_03e0);
		repeat (4) @(posedge mclk);
		sb_gate <= 1'b1;
		repeat (12) @(posedge mclk);
		sb_gate <= 1'b0;
		drain(200, 1);
		n = q.size();
		chk(32'(n > 2), 1);
		chk(q[0], {4'h2, 28'h000_0000});
		chk(q[n - 1], {12'h3a5, 20'(n - 2)});
		// timing input as pps, then sync bus reset of the timestamp
		wr(A_CTRL, 32'h0000_0220);
		repeat (30) @(posedge mclk);
		tim_in <= 1'b1;
		@(posedge mclk);
		tim_in <= 1'b0;
		repeat (5) @(posedge mclk);
		apb(1'b0, A_PPS, 32'h0000_0000);
		n = r;
		apb(1'b0, A_TS, 32'h0000_0000);
		chk(32'(n != 0 && n < r), 1);
		sb_reset <= 1'b1;
		@(posedge mclk);
		sb_reset <= 1'b0;
		apb(1'b0, A_TS, 32'h0000_0000);
		chk(32'(r < 8), 1);
		finish_test();
	end
endmodule // wad_core_tb
